// ---- include/ssp_defines.svh ----
// Constants for the sensor setup port and gain select block
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_ADDR_W 5
`define SSP_DATA_W 9
`define SSP_NREGS 32
`define SSP_REG_RST 9'h000
`define SSP_SEL_DEFAULT 4'h0
`define SSP_AV_CTRL 3'h0
`define SSP_AV_WDATA 3'h1
`define SSP_AV_RDATA 3'h2
`define SSP_AV_STATUS 3'h3
`define SSP_AV_SEL 3'h4
`define SSP_CMD_GO 0
`define SSP_CMD_RD 1
`define SSP_CMD_MASTER 2
`define SSP_CTRL_ADDR_LSB 8
`define SSP_OFFS_0 8'sh00
`define SSP_OFFS_P30 8'sh1e
`define SSP_OFFS_P60 8'sh3c
`define SSP_OFFS_P90 8'sh5a
`define SSP_OFFS_N30 (-8'sh1e)
`define SSP_OFFS_N60 (-8'sh3c)
`define SSP_OFFS_N90 (-8'sh5a)
`endif

// ---- include/ssp_pkg.sv ----
// Types shared by both ends of the setup port
`default_nettype none
package ssp_pkg;
`include "ssp_defines.svh"
   typedef logic [`SSP_ADDR_W-1:0] ssp_addr_type;
   typedef logic [`SSP_DATA_W-1:0] ssp_data_type;
   typedef logic [3:0] ssp_sel_type;
   // Gain factors of the decoded setting
   typedef enum {
      SSP_G1_00, SSP_G1_33, SSP_G2_00, SSP_G4_00, SSP_G_NA
   } ssp_gain_type;
endpackage : ssp_pkg
`default_nettype wire

// ---- include/ssp_if.sv ----
// Pin interface between the sensor setup port and its controller
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
interface ssp_if;
   import ssp_pkg::*;
   logic cs_n;
   logic wr_n;
   ssp_pkg::ssp_addr_type addr;
   ssp_pkg::ssp_data_type data_h;
   logic data_h_oe;
   ssp_pkg::ssp_data_type data_d;
   logic data_d_oe;
   logic master;
   logic gain_sel_hi;
   logic gain_sel_lo;
   logic offs_sel_hi;
   logic offs_sel_lo;
   // Resolved level of the shared data lines
   wire [`SSP_DATA_W-1:0] data =
      data_d_oe ? data_d : (data_h_oe ? data_h : '0);
   modport dev (
      input cs_n, wr_n, addr, data_h, data_h_oe, master,
      input gain_sel_hi, gain_sel_lo, offs_sel_hi, offs_sel_lo,
      output data_d, data_d_oe
   );
   modport host (
      output cs_n, wr_n, addr, data_h, data_h_oe, master,
      output gain_sel_hi, gain_sel_lo, offs_sel_hi, offs_sel_lo,
      input data_d, data_d_oe
   );
endinterface : ssp_if
`default_nettype wire

// ---- design/ssp_gain_decode.sv ----
// Decoder of the four gain and offset select bits
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_gain_decode (
   input wire ssp_pkg::ssp_sel_type sel,
   output ssp_pkg::ssp_gain_type gain,
   output logic signed [7:0] offs_cv,
   output logic valid
);
   import ssp_pkg::*;

   // Code to gain and offset in centivolts; NA codes flagged
   always_comb begin
      gain = SSP_G_NA;
      offs_cv = `SSP_OFFS_0;
      valid = 1'b1;
      unique case (sel)
         4'h0: begin
            gain = SSP_G1_00;
            offs_cv = `SSP_OFFS_0;
         end
         4'h1: begin
            gain = SSP_G1_33;
            offs_cv = `SSP_OFFS_P30;
         end
         4'h2: begin
            gain = SSP_G2_00;
            offs_cv = `SSP_OFFS_P60;
         end
         4'h3: begin
            gain = SSP_G4_00;
            offs_cv = `SSP_OFFS_P90;
         end
         4'h4: begin
            gain = SSP_G4_00;
            offs_cv = `SSP_OFFS_N30;
         end
         4'h6: begin
            gain = SSP_G4_00;
            offs_cv = `SSP_OFFS_N90;
         end
         4'h7: begin
            gain = SSP_G2_00;
            offs_cv = `SSP_OFFS_N60;
         end
         4'h9: begin
            gain = SSP_G1_33;
            offs_cv = `SSP_OFFS_N30;
         end
         default: begin
            valid = 1'b0;
         end
      endcase
   end
endmodule : ssp_gain_decode
`default_nettype wire

// ---- design/ssp_device.sv ----
// Device end: setup register file, data line direction, gain select
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_device (
   input wire logic sys_clk,
   input wire logic rst_n,
   ssp_if.dev pins,
   output ssp_pkg::ssp_gain_type gain,
   output logic signed [7:0] offs_cv,
   output logic sel_valid,
   output logic is_master
);
   import ssp_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Storage and state

   // Setup register file, contents not reset
   ssp_data_type regs [`SSP_NREGS];

   // Chip select level at the edge before
   logic cs_prev;

   // Select code in use
   ssp_sel_type sel;

   // Decoder outputs for the code in use
   ssp_gain_type dec_gain;
   logic signed [7:0] dec_offs;
   logic dec_valid;

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Chip select at its active low level
   function automatic logic ssp_selected(
      input logic cs_n
   );
      return !cs_n;
   endfunction : ssp_selected

   // Direction input at write
   function automatic logic ssp_dir_write(
      input logic wr_n
   );
      return !wr_n;
   endfunction : ssp_dir_write

   // Write strobe needs select high the cycle before
   function automatic logic ssp_write_strobe(
      input logic cs_n,
      input logic wr_n,
      input logic cs_was
   );
      return ssp_selected(cs_n) && ssp_dir_write(wr_n) && cs_was;
   endfunction : ssp_write_strobe

   // Read select: selected with the direction at read
   function automatic logic ssp_read_select(
      input logic cs_n,
      input logic wr_n
   );
      return ssp_selected(cs_n) && !ssp_dir_write(wr_n);
   endfunction : ssp_read_select

   ////////////////////////////////////////////////////////////////////
   // Cycle decode

   // Strobes of the current pin state
   wire wr_hit = ssp_write_strobe(pins.cs_n, pins.wr_n,
                                  cs_prev);
   wire rd_sel = ssp_read_select(pins.cs_n,
                                 pins.wr_n);

   // External control taken only in slave mode
   wire slave = !pins.master;

   // Live select code, gain bits above offset bits
   wire [3:0] live_sel = {pins.gain_sel_hi, pins.gain_sel_lo,
                          pins.offs_sel_hi, pins.offs_sel_lo};

   ////////////////////////////////////////////////////////////////////
   // Next values

   // Select follows the pins in slave mode, holds in master mode
   wire [3:0] next_sel = slave ? live_sel : sel;

   // Data lines driven only through a read cycle
   wire next_data_oe = rd_sel;

   // Addressed register for the read drive
   wire [`SSP_DATA_W-1:0] next_data = regs[pins.addr];

   ////////////////////////////////////////////////////////////////////
   // Setting decoder

   // Gain and offset of the code in use
   ssp_gain_decode u_dec (
      .sel(sel),
      .gain(dec_gain),
      .offs_cv(dec_offs),
      .valid(dec_valid)
   );

   ////////////////////////////////////////////////////////////////////
   // Register file

   // Store on the one low write cycle
   always_ff @(posedge sys_clk) begin
      if (wr_hit) begin
         regs[pins.addr] <= pins.data_h;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin state

   // Chip select history, idle high after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= pins.cs_n;
      end
   end

   // Mode pin copy
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         is_master <= 1'b0;
      end else begin
         is_master <= pins.master;
      end
   end

   // Select code, default setting after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sel <= `SSP_SEL_DEFAULT;
      end else begin
         sel <= next_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data line drive

   // Output enable of the data lines
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pins.data_d_oe <= 1'b0;
      end else begin
         pins.data_d_oe <= next_data_oe;
      end
   end

   // Value on the data lines
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pins.data_d <= `SSP_REG_RST;
      end else begin
         pins.data_d <= next_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decoded setting

   // Gain factor
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gain <= SSP_G1_00;
      end else begin
         gain <= dec_gain;
      end
   end

   // Offset in centivolts
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         offs_cv <= `SSP_OFFS_0;
      end else begin
         offs_cv <= dec_offs;
      end
   end

   // Setting valid flag
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sel_valid <= 1'b1;
      end else begin
         sel_valid <= dec_valid;
      end
   end
endmodule : ssp_device
`default_nettype wire

// ---- design/ssp_host.sv ----
// Controller end: Avalon-MM commanded setup port master
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_host (
   input wire logic sys_clk,
   input wire logic rst_n,
   ssp_if.host pins,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import ssp_pkg::*;

   typedef enum {SSP_IDLE, SSP_SEL, SSP_REL, SSP_RD1, SSP_RD2} ssp_st_type;
   ssp_st_type st;
   ssp_data_type wdata;
   ssp_data_type rdata;
   logic done;
   logic acked;

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   wire busy = (st != SSP_IDLE);
   wire ctrl_wr = avs_write && avs_address == `SSP_AV_CTRL;
   wire go = ctrl_wr && avs_writedata[`SSP_CMD_GO] && !busy;
   wire go_rd = avs_writedata[`SSP_CMD_RD];

   // Avalon slave, one wait cycle per access
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         acked <= 1'b0;
         wdata <= `SSP_REG_RST;
         pins.master <= 1'b0;
         {pins.gain_sel_hi, pins.gain_sel_lo} <= 2'h0;
         {pins.offs_sel_hi, pins.offs_sel_lo} <= 2'h0;
      end else begin
         acked <= (avs_read || avs_write) && !acked;
         avs_waitrequest <= !((avs_read || avs_write) && !acked);
         if (avs_write && !avs_waitrequest) begin // on the answer edge
            unique case (avs_address)
               `SSP_AV_WDATA: wdata <= avs_writedata[`SSP_DATA_W-1:0];
               `SSP_AV_SEL: begin
                  {pins.gain_sel_hi, pins.gain_sel_lo, pins.offs_sel_hi,
                   pins.offs_sel_lo} <= avs_writedata[3:0];
               end
               `SSP_AV_CTRL: pins.master <= avs_writedata[`SSP_CMD_MASTER];
               default: ;
            endcase
         end
         unique case (avs_address)
            `SSP_AV_RDATA: avs_readdata <= {23'h0, rdata};
            `SSP_AV_STATUS: avs_readdata <= {30'h0, done, busy};
            `SSP_AV_WDATA: avs_readdata <= {23'h0, wdata};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // Pin sequencer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= SSP_IDLE;
         pins.cs_n <= 1'b1;
         pins.wr_n <= 1'b1;
         pins.addr <= '0;
         pins.data_h <= '0;
         pins.data_h_oe <= 1'b0;
         rdata <= '0;
         done <= 1'b0;
      end else begin
         unique case (st)
            SSP_IDLE: if (go && !avs_waitrequest) begin
               done <= 1'b0;
               pins.addr <= avs_writedata[`SSP_CTRL_ADDR_LSB +: `SSP_ADDR_W];
               pins.wr_n <= go_rd; // set before select
               pins.data_h <= wdata;
               pins.data_h_oe <= !go_rd;
               st <= go_rd ? SSP_RD1 : SSP_SEL;
            end
            SSP_SEL: begin
               pins.cs_n <= 1'b0; // one low cycle
               st <= SSP_REL;
            end
            SSP_REL: begin
               pins.cs_n <= 1'b1;
               pins.data_h_oe <= 1'b0;
               done <= !pins.cs_n;
               st <= pins.cs_n ? SSP_REL : SSP_IDLE;
            end
            SSP_RD1: begin
               pins.cs_n <= 1'b0;
               st <= SSP_RD2;
            end
            SSP_RD2: begin
               if (pins.data_d_oe) begin
                  rdata <= pins.data_d;
                  pins.cs_n <= 1'b1;
                  done <= 1'b1;
                  st <= SSP_IDLE;
               end
            end
         endcase
      end
   end
endmodule : ssp_host
`default_nettype wire

// ---- sim/ssp_port_sva.sv ----
// Checker of the setup port pin protocol
`timescale 1ns/1ps
`default_nettype none
module ssp_port_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire ssp_pkg::ssp_addr_type addr,
   input wire logic data_h_oe,
   input wire logic data_d_oe
);
   import ssp_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Starts of a write and a read cycle
   sequence s_wr; $fell(cs_n) && !wr_n; endsequence
   sequence s_rd; $fell(cs_n) && wr_n; endsequence
   a_wr_pulse: assert property (s_wr |=> cs_n)
      else $error("write select not one cycle");
   a_wr_from_high: assert property (!cs_n && !wr_n |-> $past(cs_n))
      else $error("write without select high before");
   a_dir_stable: assert property (!cs_n && !$past(cs_n) |-> $stable(wr_n))
      else $error("direction moved while selected");
   a_no_fight: assert property (!(data_d_oe && data_h_oe))
      else $error("both ends drive data");
   a_quiet_write: assert property (!cs_n && !wr_n |-> !data_d_oe)
      else $error("device drives during write");
   a_host_drives: assert property (s_wr |-> data_h_oe)
      else $error("write data not driven");
   a_read_drive: assert property (s_rd |-> ##[1:2] data_d_oe)
      else $error("read data not driven");
   a_read_release: assert property (cs_n |=> !data_d_oe)
      else $error("data not released");
   a_addr_hold: assert property (!cs_n |-> $stable(addr))
      else $error("address moved while selected");
endmodule : ssp_port_sva
`default_nettype wire

// ---- sim/sensor_setup_port_gain_select_tb.sv ----
// Testbench joining both ends of the setup port
`timescale 1ns/1ps
`default_nettype none
module sensor_setup_port_gain_select_tb;
   import ssp_pkg::*;
   logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   logic [2:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, q;
   logic avs_waitrequest, sel_valid, is_master;
   logic signed [7:0] offs_cv;
   logic [8:0] d, mem [32];
   ssp_gain_type gain;
   int n_mismatch = 0, n_compared = 0, a, c, al [$];
   int eo [10] = '{0, 30, 60, 90, -30, 0, -90, -60, 0, -30};
   ssp_gain_type eg [10] = '{SSP_G1_00, SSP_G1_33, SSP_G2_00, SSP_G4_00,
      SSP_G4_00, SSP_G_NA, SSP_G4_00, SSP_G2_00, SSP_G_NA, SSP_G1_33};
   ssp_if bus ();
   ssp_device ssp_device_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .pins(bus.dev), .gain(gain), .offs_cv(offs_cv),
      .sel_valid(sel_valid), .is_master(is_master));
   ssp_host ssp_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .pins(bus.host),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   ssp_port_sva ssp_port_sva_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .cs_n(bus.cs_n), .wr_n(bus.wr_n), .addr(bus.addr),
      .data_h_oe(bus.data_h_oe), .data_d_oe(bus.data_d_oe));
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_compared++;
      if (seen !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk
   // One Avalon access, held until waitrequest is seen low
   task av(input logic [2:0] ad, input logic r, input logic [31:0] wd);
      @(posedge sys_clk);
      avs_address <= ad;
      avs_read <= r;
      avs_write <= !r;
      avs_writedata <= wd;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask : av
   // Link cycle ordered through the control word, then wait for idle
   task go(input logic [4:0] ra, input logic rd);
      av(0, 0, {19'b0, ra, 6'b0, rd, 1'b1});
      do av(3, 1, 0); while (q[0] !== 1'b0);
      chk("done", q[1], 1);
   endtask : go
   task settle;
      repeat (4) @(posedge sys_clk);
   endtask : settle
   task final_report;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial forever #20 sys_clk = !sys_clk;
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_mismatch++;
      final_report();
   end
   // Main sequence
   initial begin
      void'($urandom(54747));
      repeat (16) @(posedge sys_clk);
      rst_n <= 1;
      settle();
      chk("gain", gain, SSP_G1_00);
      chk("offs", offs_cv, 0);
      chk("valid", sel_valid, 1);
      chk("master", is_master, 0);
      for (c = 0; c < 16; c++) begin
         av(4, 0, c);
         settle();
         chk("gain", gain, c < 10 ? eg[c] : SSP_G_NA);
         chk("offs", offs_cv, c < 10 ? eo[c] : 0);
         chk("valid", sel_valid, c < 10 && c != 5 && c != 8);
      end
      $display("test select codes done");
      av(0, 0, 32'h4);
      av(4, 0, 32'h3);
      settle();
      chk("master", is_master, 1);
      chk("gain", gain, SSP_G_NA);
      av(0, 0, 32'h0);
      settle();
      chk("gain", gain, SSP_G4_00);
      chk("offs", offs_cv, 90);
      $display("test mode done");
      for (int i = 0; i < 12; i++) begin
         a = i == 1 ? 31 : i < 3 ? 0 : $urandom % 32;
         d = 9'($urandom);
         av(1, 0, {23'b0, d});
         av(1, 1, 0);
         chk("wdata", q, {23'b0, d});
         go(a[4:0], 0);
         mem[a] = d;
         al.push_back(a);
      end
      foreach (al[i]) begin
         go(al[i][4:0], 1);
         av(2, 1, 0);
         chk("reg", q, {23'b0, mem[al[i]]});
      end
      av(5, 1, 0);
      chk("unmapped", q, 0);
      $display("test registers done");
      final_report();
   end
endmodule : sensor_setup_port_gain_select_tb
`default_nettype wire
